// *** shared/pcs_pkg.sv ***
// Purpose: constants and types shared by the cycle scheduler files
// Assumes: core_clk at 20 MHz, all times counted in 0.1 ms ticks
// Notes:   register data is 16 bits wide, offsets are word addresses
// Overview of operation
// - Servicing cycle over 2 s: flag, halt
// - Servicing cycle word counts 0.1 ms, 0..2000.0
// - Exec time 32 bits, low word first
// - Normal mode counts only instruction execution
// - Program cycle opens with 0.3 ms oversee
// - Minimum-cycle evaluation precedes cyclic servicing
// - Refresh each unit, then bus units
// - File window budget configurable, default 4%
// - Servicing cycle opens with 0.2 ms oversee
// - Servicing cycle serves every requesting source except sync-mode memory events
// - Each single service limited to 1 s
// - Async mode: memory events run in parallel
// - Sync mode: memory events in file window
// - Network codes 01/23 access I/O memory
// - Host-link memory commands too, except panel links
// - Mode 00/01/02/05+ decoded, 03/04 setup error
package pcs_pkg;
  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          TICK_NS         = 100000;
  localparam int          TICK_CYC        = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PROG_OVS_US     = 300;
  localparam int          SVC_OVS_US      = 200;
  localparam int          SVC_MAX_MS      = 1000;
  localparam int          OVR_MS          = 2000;
  localparam logic [15:0] PROG_OVS_TICKS  = 16'(PROG_OVS_US * 1000 / TICK_NS);
  localparam logic [15:0] SVC_OVS_TICKS   = 16'(SVC_OVS_US * 1000 / TICK_NS);
  localparam logic [15:0] SVC_MAX_TICKS   = 16'(SVC_MAX_MS * 10);
  localparam logic [15:0] OVR_TICKS       = 16'(OVR_MS * 10);
  localparam logic [15:0] FILE_PCT_DIV    = 16'h0019;
  // Register word addresses
  localparam logic [11:0] A_CTRL          = 12'h100;
  localparam logic [11:0] A_MODE          = 12'h101;
  localparam logic [11:0] A_UNITS         = 12'h102;
  localparam logic [11:0] A_FBUD          = 12'h103;
  localparam logic [11:0] A_STAT          = 12'h104;
  localparam logic [11:0] A_MASK          = 12'h105;
  localparam logic [11:0] A_EXEC_LO       = 12'h10a;
  localparam logic [11:0] A_EXEC_HI       = 12'h10b;
  localparam logic [11:0] A_SCYC          = 12'h10c;
  // Status bit positions
  localparam int          ST_OVR          = 0;
  localparam int          ST_SETUP        = 1;
  localparam int          ST_SVC_TO       = 2;
  localparam int          ST_CYC_DONE     = 3;
  localparam int          ST_HALT         = 4;
  localparam logic [3:0]  STAT_RST        = 4'h0;
  // Command classification codes
  localparam logic [7:0]  CMD_MEM_RW      = 8'h01;
  localparam logic [7:0]  CMD_FORCE       = 8'h23;
  localparam logic [7:0]  MODE_NORM       = 8'h00;
  localparam logic [7:0]  MODE_SYNC       = 8'h01;
  localparam logic [7:0]  MODE_ASYNC      = 8'h02;
  localparam logic [7:0]  MODE_PRIO_MIN   = 8'h05;

  typedef enum logic [2:0] {
    M_NORM = 3'b000, M_SYNC = 3'b001, M_ASYNC = 3'b011, M_PRIO = 3'b010, M_BAD = 3'b110
  } pcs_mode_e;
  typedef enum logic [2:0] {
    P_IDLE = 3'b000, P_OVS = 3'b001, P_EXEC = 3'b011, P_MINC = 3'b010,
    P_REFR = 3'b110, P_BUSR = 3'b111, P_FILE = 3'b101
  } pcs_prog_e;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_OVS = 2'b01, S_SVC = 2'b11
  } pcs_svc_e;
endpackage

// *** design/pcs_tick.sv ***
// Purpose: 0.1 ms tick enable from the core clock
// Assumes: single clock domain
// Notes:   period is a parameter so simulation can shorten it
`timescale 1ns/1ns
module pcs_tick import pcs_pkg::*; #(
  parameter int CYC = TICK_CYC
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Enable out
  output logic      tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tk;
  } pcs_tick_s;
  pcs_tick_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tk = 1'b0;
    if (s_q.cnt == 16'(CYC - 1)) begin
      s_d.cnt = 16'h0000;
      s_d.tk = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tk;

  chk_tick_spacing: assert property (@(posedge core_clk) disable iff (!arst_n)
    tick |=> !tick) else $error("tick lasted more than one cycle");
endmodule // pcs_tick

// *** design/pcs_class.sv ***
// Purpose: decide whether an incoming event touches I/O memory
// Assumes: command fields are stable while the event is offered
// Notes:   purely combinational, no state
`timescale 1ns/1ns
module pcs_class import pcs_pkg::*; (
  // Event description
  input  wire logic       ev_hostlink,
  input  wire logic [7:0] ev_code,
  input  wire logic       ev_hl_mem,
  input  wire logic       ev_panel,
  // Result
  output logic            ev_mem
);
  always_comb begin
    if (!ev_hostlink) begin
      ev_mem = (ev_code == CMD_MEM_RW) || (ev_code == CMD_FORCE);
    end else begin
      ev_mem = ev_hl_mem && !ev_panel;
    end
  end
endmodule // pcs_class

// *** design/pcs_sched.sv ***
// Purpose: program cycle and servicing cycle scheduler with time monitors
// Assumes: event and refresh partners are logic on core_clk
// Notes:   one service in flight at a time; overrun halts until reset
`timescale 1ns/1ns
module pcs_sched import pcs_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Event requests
  input  wire logic        ev_valid,
  output logic             ev_ready,
  input  wire logic        ev_hostlink,
  input  wire logic [7:0]  ev_code,
  input  wire logic        ev_hl_mem,
  input  wire logic        ev_panel,
  // Service engine
  output logic             svc_go,
  output logic      [7:0]  svc_cmd,
  output logic             svc_abort,
  input  wire logic        svc_done,
  // Program cycle phases
  output logic             exec_en,
  input  wire logic        exec_done,
  output logic             refr_req,
  output logic      [7:0]  refr_unit,
  input  wire logic        refr_ack,
  output logic             busr_req,
  input  wire logic        busr_ack,
  output logic             file_en,
  // Status
  output logic             servicing_overrun_flag,
  output logic             irq
);
  typedef struct packed {
    pcs_prog_e   prog;
    pcs_svc_e    svc;
    pcs_mode_e   act;
    logic [15:0] ptick;
    logic [15:0] stk;
    logic [7:0]  unit;
    logic [31:0] ecnt;
    logic [31:0] eword;
    logic [15:0] cyc;
    logic [15:0] lastc;
    logic [15:0] fbud;
    logic [15:0] scnt;
    logic [15:0] sword;
    logic [15:0] svct;
    logic        busy;
    logic        go;
    logic        abort;
    logic [7:0]  cmd;
    logic [7:0]  mode;
    logic        run;
    logic [7:0]  units;
    logic [15:0] fcfg;
    logic [3:0]  st;
    logic [3:0]  mask;
    logic        ovr;
    logic [15:0] rdata;
  } pcs_main_s;
  pcs_main_s s_q, s_d;

  logic tick;
  logic ev_mem;
  logic par;
  logic sync_m;
  logic ok_svc;
  logic ok_file;
  logic accept;

  pcs_tick #(.CYC(TICK_CYCLES)) u_tick (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .tick     (tick)
  );

  pcs_class u_class (
    .ev_hostlink (ev_hostlink),
    .ev_code     (ev_code),
    .ev_hl_mem   (ev_hl_mem),
    .ev_panel    (ev_panel),
    .ev_mem      (ev_mem)
  );

  function automatic pcs_mode_e mode_of(input logic [7:0] m);
    if (m == MODE_NORM) begin
      mode_of = M_NORM;
    end else if (m == MODE_SYNC) begin
      mode_of = M_SYNC;
    end else if (m == MODE_ASYNC) begin
      mode_of = M_ASYNC;
    end else if (m >= MODE_PRIO_MIN) begin
      mode_of = M_PRIO;
    end else begin
      mode_of = M_BAD;
    end
  endfunction

  assign par    = (s_q.act == M_SYNC) || (s_q.act == M_ASYNC);
  assign sync_m = (s_q.act == M_SYNC);
  // async memory events in parallel cycle
  // sync memory events wait for file window
  assign ok_svc  = (s_q.svc == S_SVC) && par && !(sync_m && ev_mem);
  assign ok_file = (s_q.prog == P_FILE) && (!par || (sync_m && ev_mem));
  // Handshake may be combinational; never stalls a partner twice
  assign ev_ready = s_q.run && !s_q.busy && (ok_svc || ok_file);
  assign accept   = ev_valid && ev_ready;

  always_comb begin
    logic [3:0] st_set;
    st_set = 4'h0;
    s_d = s_q;
    s_d.go    = 1'b0;
    s_d.abort = 1'b0;
    s_d.rdata = 16'h0000;
    if (tick && s_q.prog != P_IDLE && s_q.cyc != 16'hffff) begin
      s_d.cyc = s_q.cyc + 16'h0001;
    end
    // One service at a time
    if (accept) begin
      s_d.busy = 1'b1;
      s_d.go   = 1'b1;
      s_d.cmd  = ev_code;
      s_d.svct = 16'h0000;
    end else if (s_q.busy) begin
      if (svc_done) begin
        s_d.busy = 1'b0;
      end else if (s_q.svct >= SVC_MAX_TICKS) begin
        s_d.busy  = 1'b0;
        s_d.abort = 1'b1;
        st_set[ST_SVC_TO] = 1'b1;
      end else if (tick) begin
        s_d.svct = s_q.svct + 16'h0001;
      end
    end
    // Program cycle
    case (s_q.prog)
      P_IDLE: begin
        if (s_q.run) begin
          s_d.prog  = P_OVS;
          s_d.ptick = 16'h0000;
          s_d.cyc   = 16'h0000;
        end
      end
      P_OVS: begin
        if (tick) begin
          s_d.ptick = s_q.ptick + 16'h0001;
          if (s_q.ptick == PROG_OVS_TICKS - 16'h0001) begin
            s_d.prog = P_EXEC;
            s_d.ecnt = 32'h0;
          end
        end
      end
      P_EXEC: begin
        // only execution time counts
        // Last tick folded into the word so the count never moves after exit
        if (tick && !exec_done) begin
          s_d.ecnt = s_q.ecnt + 32'h1;
        end
        if (exec_done) begin
          s_d.prog  = P_MINC;
          s_d.eword = s_q.ecnt + {31'h0, tick};
        end
      end
      P_MINC: begin
        // default is 4% of last cycle
        if (s_q.fcfg != 16'h0000) begin
          s_d.fbud = s_q.fcfg;
        end else if (s_q.lastc < FILE_PCT_DIV) begin
          s_d.fbud = 16'h0001;
        end else begin
          s_d.fbud = s_q.lastc / FILE_PCT_DIV;
        end
        s_d.unit = 8'h00;
        s_d.prog = (s_q.units == 8'h00) ? P_BUSR : P_REFR;
      end
      P_REFR: begin
        if (refr_ack) begin
          s_d.unit = s_q.unit + 8'h01;
          if (s_q.unit == s_q.units - 8'h01) begin
            s_d.prog = P_BUSR;
          end
        end
      end
      P_BUSR: begin
        if (busr_ack) begin
          s_d.prog  = P_FILE;
          s_d.ptick = 16'h0000;
        end
      end
      P_FILE: begin
        // window stretches for a service in flight
        if (tick && s_q.ptick != 16'hffff) begin
          s_d.ptick = s_q.ptick + 16'h0001;
        end
        if (s_q.ptick >= s_q.fbud && !s_q.busy) begin
          s_d.lastc = s_q.cyc;
          st_set[ST_CYC_DONE] = 1'b1;
          s_d.prog  = s_q.run ? P_OVS : P_IDLE;
          s_d.ptick = 16'h0000;
          s_d.cyc   = 16'h0000;
        end
      end
      default: s_d.prog = P_IDLE;
    endcase
    // Servicing cycle
    case (s_q.svc)
      S_IDLE: begin
        if (s_q.run && par) begin
          s_d.svc  = S_OVS;
          s_d.stk  = 16'h0000;
          s_d.scnt = 16'h0000;
        end
      end
      S_OVS: begin
        if (tick) begin
          s_d.stk = s_q.stk + 16'h0001;
          if (s_q.stk == SVC_OVS_TICKS - 16'h0001) begin
            s_d.svc = S_SVC;
          end
        end
      end
      S_SVC: begin
        if (!s_q.busy && !(ev_valid && ok_svc)) begin
          s_d.sword = s_q.scnt;
          s_d.svc  = S_OVS;
          s_d.stk  = 16'h0000;
          s_d.scnt = 16'h0000;
        end
      end
      default: s_d.svc = S_IDLE;
    endcase
    if (s_q.svc != S_IDLE && tick && s_d.svc == s_q.svc) begin
      if (s_q.scnt < OVR_TICKS) begin
        s_d.scnt = s_q.scnt + 16'h0001;
      end else begin
        s_d.scnt = OVR_TICKS;
        s_d.ovr  = 1'b1;
        s_d.sword = OVR_TICKS;
        st_set[ST_OVR] = 1'b1;
      end
    end
    // Register writes; hardware sets win over clears
    if (reg_wr) begin
      case (reg_addr)
        A_CTRL: begin
          if (reg_wdata[0] && !s_q.run && !s_q.ovr) begin
            // mode takes effect at start of run
            s_d.act = mode_of(s_q.mode);
            if (mode_of(s_q.mode) == M_BAD) begin
              st_set[ST_SETUP] = 1'b1;
            end
          end
          s_d.run = reg_wdata[0] && !s_q.ovr;
        end
        A_MODE:  s_d.mode  = reg_wdata[7:0];
        A_UNITS: s_d.units = reg_wdata[7:0];
        A_FBUD:  s_d.fcfg  = reg_wdata;
        A_STAT:  s_d.st    = s_q.st & ~reg_wdata[3:0];
        A_MASK:  s_d.mask  = reg_wdata[3:0];
        default: ;
      endcase
    end
    // Sets applied after the clear so an event in the clear cycle is kept
    s_d.st = s_d.st | st_set;
    if (s_d.ovr) begin
      s_d.run  = 1'b0;
      s_d.prog = P_IDLE;
      s_d.svc  = S_IDLE;
    end
    if (s_d.svc != S_IDLE && !(s_d.run && par)) begin
      s_d.svc = S_IDLE;
    end
    if (reg_rd) begin
      case (reg_addr)
        A_CTRL:    s_d.rdata = {15'h0000, s_q.run};
        A_MODE:    s_d.rdata = {8'h00, s_q.mode};
        A_UNITS:   s_d.rdata = {8'h00, s_q.units};
        A_FBUD:    s_d.rdata = s_q.fcfg;
        A_STAT:    s_d.rdata = {11'h000, s_q.ovr, s_q.st};
        A_MASK:    s_d.rdata = {12'h000, s_q.mask};
        A_EXEC_LO: s_d.rdata = s_q.eword[15:0];
        A_EXEC_HI: s_d.rdata = s_q.eword[31:16];
        A_SCYC:    s_d.rdata = s_q.sword;
        default:   s_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q       <= '0;
      s_q.prog  <= P_IDLE;
      s_q.svc   <= S_IDLE;
      s_q.act   <= M_NORM;
      s_q.st    <= STAT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata              = s_q.rdata;
  assign svc_go                 = s_q.go;
  assign svc_cmd                = s_q.cmd;
  assign svc_abort              = s_q.abort;
  assign exec_en                = (s_q.prog == P_EXEC);
  assign refr_req               = (s_q.prog == P_REFR);
  assign refr_unit              = s_q.unit;
  assign busr_req               = (s_q.prog == P_BUSR);
  assign file_en                = (s_q.prog == P_FILE);
  assign servicing_overrun_flag = s_q.ovr;
  assign irq                    = |(s_q.st & s_q.mask);

  chk_overrun_halt: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_q.ovr |-> !s_q.run && s_q.prog == P_IDLE) else $error("overrun did not halt");
  chk_scyc_range: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_q.sword <= OVR_TICKS) else $error("servicing word out of range");
  chk_exec_hi_read: assert property (@(posedge core_clk) disable iff (!arst_n)
    reg_rd && reg_addr == A_EXEC_HI |=> reg_rdata == $past(s_q.eword[31:16]))
    else $error("high exec word wrong");
  chk_exec_only: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_q.prog != P_EXEC && $past(s_q.prog) != P_OVS |-> $stable(s_q.ecnt))
    else $error("exec count moved outside execution");
  sequence seq_ovs_leave;
    s_q.prog == P_OVS ##1 s_q.prog == P_EXEC;
  endsequence
  chk_prog_ovs_len: assert property (@(posedge core_clk) disable iff (!arst_n)
    seq_ovs_leave |-> s_q.ptick == PROG_OVS_TICKS) else $error("program oversee length");
  chk_minc_first: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(refr_req) |-> $past(s_q.prog) == P_MINC) else $error("refresh without evaluation");
  chk_units_done: assert property (@(posedge core_clk) disable iff (!arst_n)
    $past(s_q.prog) == P_REFR && s_q.prog == P_BUSR |-> s_q.unit == s_q.units)
    else $error("unit refresh skipped");
  chk_file_budget: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_q.prog == P_FILE && s_d.prog != P_FILE && !s_d.ovr |-> s_q.ptick >= s_q.fbud)
    else $error("file window cut short");
  chk_svc_ovs_len: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_q.svc == S_OVS ##1 s_q.svc == S_SVC |-> s_q.stk == SVC_OVS_TICKS)
    else $error("servicing oversee length");
  chk_svc_limit: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_q.busy |-> s_q.svct <= SVC_MAX_TICKS) else $error("service over limit");
  // sync memory events only in file window
  chk_sync_mem: assert property (@(posedge core_clk) disable iff (!arst_n)
    accept && sync_m && ev_mem |-> s_q.prog == P_FILE) else $error("sync memory event early");
  chk_svc_restart: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_q.svc == S_SVC ##1 s_q.svc == S_OVS |-> s_q.scnt == 16'h0000)
    else $error("servicing time not restarted");
endmodule // pcs_sched

// *** verif/pcs_far.sv ***
// Purpose: far side model, service engine and program cycle partners
// Assumes: every answer is registered on core_clk, one service at a time
// Notes:   hang holds a service open so the 1 s limit is reached
`timescale 1ns/1ns
module pcs_far #(
  parameter int EX_LEN = 198
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Bench control
  input  wire logic hang,
  // Scheduler side
  input  wire logic svc_go,
  input  wire logic svc_abort,
  output logic      svc_done,
  input  wire logic exec_en,
  output logic      exec_done,
  input  wire logic refr_req,
  output logic      refr_ack,
  input  wire logic busr_req,
  output logic      busr_ack
);
  logic       sb;
  logic [9:0] sc;
  logic [9:0] ec;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {sb, sc, ec, svc_done, exec_done, refr_ack, busr_ack} <= '0;
    end else begin
      // Abort drops the service, else a later done would be stray
      sb        <= svc_go | (sb & ~svc_done & ~svc_abort);
      sc        <= svc_go ? 10'h000 : sc + 10'h001;
      svc_done  <= sb & ~svc_done & ~hang & (sc == 10'h005);
      ec        <= exec_en ? ec + 10'h001 : 10'h000;
      exec_done <= exec_en & ~exec_done & (ec == 10'(EX_LEN));
      // Acks every other cycle, slower than the requester
      refr_ack  <= refr_req & ~refr_ack;
      busr_ack  <= busr_req & ~busr_ack;
    end
  end
endmodule // pcs_far

// *** verif/pcs_sched_tb_top.sv ***
// Purpose: self-checking bench for the cycle scheduler
// Assumes: tick shortened to 4 core_clk cycles
// Notes:   overrun runs last, the halt is sticky until reset
`timescale 1ns/1ns
module pcs_sched_tb_top import pcs_pkg::*;;
  logic        core_clk = 1'b0, arst_n = 1'b0, hang = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, ev_valid = 1'b0, ev_hostlink = 1'b0;
  logic [7:0]  ev_code = 8'h00, svc_cmd, refr_unit;
  logic        ev_hl_mem = 1'b0, ev_panel = 1'b0, ax, af;
  logic        ev_ready, svc_go, svc_abort, svc_done, exec_en, exec_done;
  logic        refr_req, refr_ack, busr_req, busr_ack, file_en;
  logic        servicing_overrun_flag, irq;
  int          num_errors = 0, cmp_count = 0, n, i, m;
  longint      t0;
  // Fields: host-link, host mem, panel, expected mem, code
  logic [11:0] tbl [7] = '{12'h101, 12'h123, 12'h005, 12'h410, 12'hd00, 12'he00, 12'h800};

  pcs_sched #(.TICK_CYCLES(4)) dut (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ev_valid, .ev_ready, .ev_hostlink, .ev_code, .ev_hl_mem,
    .ev_panel, .svc_go, .svc_cmd, .svc_abort, .svc_done, .exec_en, .exec_done,
    .refr_req, .refr_unit, .refr_ack, .busr_req, .busr_ack, .file_en,
    .servicing_overrun_flag, .irq);
  pcs_far far (.core_clk, .arst_n, .hang, .svc_go, .svc_abort, .svc_done, .exec_en,
    .exec_done, .refr_req, .refr_ack, .busr_req, .busr_ack);

  always #25 core_clk = ~core_clk;

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic chkr(input string s, input int lo, input int hi, input logic [31:0] g);
    cmp_count++;
    if ($isunknown(g) || g < lo || g > hi) begin
      num_errors++;
      $display("wrong value %s expected %0d to %0d seen %0d", s, lo, hi, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask

  // Offer one event, note the phase that took it
  task automatic ev(input logic [11:0] t, input bit al);
    if (al) begin
      while (exec_en) @(negedge core_clk);
      while (!exec_en) @(negedge core_clk);
    end
    @(posedge core_clk);
    ev_valid <= 1'b1;
    {ev_hostlink, ev_hl_mem, ev_panel} <= t[11:9];
    ev_code  <= t[7:0];
    do @(negedge core_clk); while (!ev_ready);
    ax = exec_en;
    af = file_en;
    @(posedge core_clk);
    ev_valid <= 1'b0;
    @(negedge core_clk);
    chk("svc_go cmd", {1'b1, t[7:0]}, {svc_go, svc_cmd});
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole run is near 90000 cycles
  initial begin
    repeat (99000) @(posedge core_clk);
    num_errors++;
    close_out;
  end

  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    wr(A_EXEC_LO, 16'hffff);
    rd(A_EXEC_LO, d);
    chk("exec_lo ro", 0, d);
    rd(A_STAT, d);
    chk("stat reset", STAT_RST, d);
    rd(12'h1ff, d);
    chk("unmapped", 0, d);
    $display("test registers done");
    for (m = 3; m < 5; m++) begin
      wr(A_MODE, 16'(m));
      wr(A_CTRL, 16'h0001);
      rd(A_STAT, d);
      chk("setup error", 16'h0002, d & 16'h0002);
      wr(A_MASK, 16'h0002);
      @(negedge core_clk);
      chk("irq raised", 1, irq);
      wr(A_CTRL, 16'h0000);
      wr(A_STAT, 16'h000f);
      @(negedge core_clk);
      chk("irq cleared", 0, irq);
    end
    $display("test setup error done");
    // Let the cycle started by the setup runs drain to idle
    repeat (400) @(negedge core_clk);
    wr(A_MODE, 16'h0000);
    wr(A_UNITS, 16'h0003);
    wr(A_FBUD, 16'h0005);
    wr(A_CTRL, 16'h0001);
    n = 0;
    while (!exec_en) begin
      @(negedge core_clk);
      n++;
    end
    chkr("oversee len", 8, 16, n);
    while (exec_en) @(negedge core_clk);
    chk("eval gap", 0, refr_req);
    for (i = 0; i < 3; i++) begin
      do @(negedge core_clk); while (!refr_ack);
      chk("refresh unit", i, refr_unit);
    end
    while (!busr_req) @(negedge core_clk);
    chk("bus refresh last", 0, refr_req);
    while (!file_en) @(negedge core_clk);
    n = 0;
    while (file_en) begin
      @(negedge core_clk);
      n++;
    end
    chkr("file window", 16, 24, n);
    rd(A_EXEC_LO, d);
    chkr("exec lo", 49, 51, d);
    rd(A_EXEC_HI, d);
    chk("exec hi", 0, d);
    $display("test program cycle done");
    // Mode 0 normal, 1 sync, 2 async; mode 2 stays running
    for (m = 0; m < 3; m++) begin
      wr(A_CTRL, 16'h0000);
      wr(A_MODE, 16'(m));
      wr(A_CTRL, 16'h0001);
      for (i = 0; i < 7; i++) begin
        ev(tbl[i], 1'b1);
        chk("accept phase", (m == 0 || (m == 1 && tbl[i][8])) ? 2'b01 : 2'b10, {ax, af});
      end
      $display("test mode %0d events done", m);
    end
    for (i = 0; i < 2; i++) begin
      while (!exec_en) @(negedge core_clk);
      while (exec_en) @(negedge core_clk);
      rd(A_SCYC, d);
      chkr("servicing word", 1, 8, d);
    end
    $display("test servicing word done");
    @(posedge core_clk);
    hang <= 1'b1;
    ev(12'h005, 1'b1);
    t0 = $time / 50;
    // Second event waits so the servicing cycle never closes
    ev(12'h005, 1'b0);
    chkr("service limit", 39990, 40012, ($time / 50) - t0);
    chk("no overrun yet", 0, servicing_overrun_flag);
    rd(A_STAT, d);
    chk("service timeout", 16'h0004, d & 16'h0004);
    n = 0;
    while (!servicing_overrun_flag && n < 40000) begin
      @(negedge core_clk);
      n++;
    end
    chkr("overrun time", 1, 39999, n);
    rd(A_STAT, d);
    chk("overrun stat", 16'h0011, d & 16'h0011);
    wr(A_CTRL, 16'h0001);
    repeat (20) @(negedge core_clk);
    chk("halted", 0, exec_en);
    $display("test overrun done");
    close_out;
  end
endmodule // pcs_sched_tb_top
